// [ccr_regs.v]
// Functional notes
// RULE_01 - the low nibble of sysref_delay_ctrl sets the frame-reference delay in 20 ps steps, codes 0 to 15, reset 0.
// RULE_02 - sysref_delay_ctrl lives at 0x032, resets to 0x80, with a read/write upper nibble defaulting to 1000.
// RULE_03 - analog_misc_ctrl lives at 0x033, resets to 0xc3, keeping its spare bits at their defaults.
// RULE_04 - bit 2 of analog_misc_ctrl powers down the differential sync inputs and resets to 0.
// RULE_05 - software using the differential sync input keeps the power-down bit cleared.
// RULE_06 - input_clamp_ctrl lives at 0x034, resets to 0x2f, and its bit 5 enables the input clamp.
// RULE_07 - clearing the clamp bit disables the clamp, setting it enables it again, reset value one.
// RULE_08 - lane_driver_cfg lives at 0x040, resets to 0x04, and 0x041 to 0x04f are reserved.
// RULE_09 - lane_driver_cfg bits 3..0 set driver pre-emphasis with default 4, bits 7..4 reserved and zero.
// RULE_10 - the calibration group spans 0x050 to 0x1ff with 0x06c upward reserved.
// RULE_11 - cal_config_0 lives at 0x050, resets to 0x06, bit 4 vector access enable, bit 3 cal trigger.
// RULE_12 - writing one to the trigger restarts the calibration engine and the bit clears itself.
// RULE_13 - with vector access enabled, cal_coeff_scan reads and writes the calibration vectors.
// RULE_14 - spare read/write fields store what is written and reset to their defaults.
`include "ccr_defines.vh"
`default_nettype none
module ccr_regs (
	input wire core_clk,
	input wire srst,
	input wire [`CCR_ADDR_W-1:0] reg_addr,
	input wire reg_wr_en,
	input wire [7:0] reg_wr_data,
	input wire reg_rd_en,
	input wire [7:0] cal_status_in,
	output reg [7:0] reg_rd_data,
	output reg reg_rd_valid,
	output wire [3:0] sysref_delay_step,
	output wire sync_diff_powerdown,
	output wire input_clamp_en,
	output wire [3:0] lane_preemphasis,
	output wire vector_access_en,
	output reg foreground_cal_trigger,
	output wire [7:0] cal_config_1_out,
	output wire [7:0] background_cal_out,
	output wire [7:0] test_pattern_overrange_out,
	output wire [7:0] timing_cal_out
);
	reg [7:0] sysref_delay_ctrl;
	reg [7:0] analog_misc_ctrl;
	reg [7:0] input_clamp_ctrl;
	reg [7:0] lane_driver_cfg;
	reg [7:0] cal_config_0;
	reg [7:0] cal_config_1;
	reg [7:0] background_cal_ctrl;
	reg [7:0] test_pattern_overrange_en;
	reg [7:0] cal_coeff_scan;
	reg [`CCR_VEC_AW-1:0] vec_ptr;
	wire [`CCR_VEC_W-1:0] vec_q;
	wire scan_hit;
	wire vec_we;
	reg [7:0] timing_cal_ctrl;
	// strobes for the calibration control register and for opening the scan port
	wire cfg0_wr;
	wire scan_open;

	// address match, shared by the write and scan decode; the read mux decodes with a case
	function sel;
		input [`CCR_ADDR_W-1:0] a;
		input [`CCR_ADDR_W-1:0] off;
		begin
			sel = (a == off);
		end
	endfunction

	// control fields come straight off the register flops
	assign sysref_delay_step = sysref_delay_ctrl[`CCR_DELAY_MSB:`CCR_DELAY_LSB]; // RULE_01
	assign sync_diff_powerdown = analog_misc_ctrl[`CCR_SYNC_PD_BIT]; // RULE_04
	assign input_clamp_en = input_clamp_ctrl[`CCR_CLAMP_EN_BIT]; // RULE_06
	assign lane_preemphasis = lane_driver_cfg[`CCR_PREEMPH_MSB:`CCR_PREEMPH_LSB]; // RULE_09
	assign vector_access_en = cal_config_0[`CCR_VEC_EN_BIT]; // RULE_11
	assign cal_config_1_out = cal_config_1;
	assign background_cal_out = background_cal_ctrl;
	assign test_pattern_overrange_out = test_pattern_overrange_en;
	assign timing_cal_out = timing_cal_ctrl;

	// scan port goes to the vector store only while access is enabled
	assign scan_hit = sel(reg_addr, `CCR_OFF_COEFF_SCAN) & cal_config_0[`CCR_VEC_EN_BIT]; // RULE_13
	assign vec_we = reg_wr_en & scan_hit; // RULE_13
	assign cfg0_wr = reg_wr_en & sel(reg_addr, `CCR_OFF_CAL_CONFIG_0);
	// only a 0 to 1 change of the access bit rewinds, so rewriting it keeps the place
	assign scan_open = cfg0_wr & reg_wr_data[`CCR_VEC_EN_BIT] & ~cal_config_0[`CCR_VEC_EN_BIT]; // RULE_13

	ccr_vec_mem u_vec_mem (
		.core_clk(core_clk),
		.we(vec_we),
		.addr(vec_ptr),
		.wdata(reg_wr_data),
		.rdata(vec_q)
	);

	// register writes, one process per register; a write and a read in one cycle both take effect
	// frame-reference delay; the spare upper nibble stores as written
	always @(posedge core_clk) begin
		if (srst) begin
			sysref_delay_ctrl <= `CCR_RST_SYSREF_DELAY; // RULE_02
		end else if (reg_wr_en & sel(reg_addr, `CCR_OFF_SYSREF_DELAY)) begin
			sysref_delay_ctrl <= reg_wr_data; // RULE_01
		end
	end

	// analog controls; only bit 2 leaves the block, the rest are spare storage
	always @(posedge core_clk) begin
		if (srst) begin
			analog_misc_ctrl <= `CCR_RST_ANALOG_MISC; // RULE_03
		end else if (reg_wr_en & sel(reg_addr, `CCR_OFF_ANALOG_MISC)) begin
			analog_misc_ctrl <= reg_wr_data; // RULE_04
		end
	end

	// input clamp; comes out of reset with the clamp on
	always @(posedge core_clk) begin
		if (srst) begin
			input_clamp_ctrl <= `CCR_RST_INPUT_CLAMP; // RULE_07
		end else if (reg_wr_en & sel(reg_addr, `CCR_OFF_INPUT_CLAMP)) begin
			input_clamp_ctrl <= reg_wr_data; // RULE_07
		end
	end

	// lane driver; upper nibble is reserved zero, so only the pre-emphasis bits store
	always @(posedge core_clk) begin
		if (srst) begin
			lane_driver_cfg <= `CCR_RST_LANE_DRIVER; // RULE_08
		end else if (reg_wr_en & sel(reg_addr, `CCR_OFF_LANE_DRIVER)) begin
			lane_driver_cfg <= {4'h0, reg_wr_data[3:0]}; // RULE_09
		end
	end

	// calibration range setting, kept whole
	always @(posedge core_clk) begin
		if (srst) begin
			cal_config_1 <= `CCR_RST_CAL_CONFIG_1; // RULE_14
		end else if (reg_wr_en & sel(reg_addr, `CCR_OFF_CAL_CONFIG_1)) begin
			cal_config_1 <= reg_wr_data; // RULE_14
		end
	end

	// background calibration control, passed straight out
	always @(posedge core_clk) begin
		if (srst) begin
			background_cal_ctrl <= `CCR_RST_BG_CAL;
		end else if (reg_wr_en & sel(reg_addr, `CCR_OFF_BG_CAL)) begin
			background_cal_ctrl <= reg_wr_data;
		end
	end

	// test pattern and over-range enables
	always @(posedge core_clk) begin
		if (srst) begin
			test_pattern_overrange_en <= `CCR_RST_PAT_OVR;
		end else if (reg_wr_en & sel(reg_addr, `CCR_OFF_PAT_OVR)) begin
			test_pattern_overrange_en <= reg_wr_data;
		end
	end

	// timing calibration control
	always @(posedge core_clk) begin
		if (srst) begin
			timing_cal_ctrl <= `CCR_RST_TIMING_CAL;
		end else if (reg_wr_en & sel(reg_addr, `CCR_OFF_TIMING_CAL)) begin
			timing_cal_ctrl <= reg_wr_data;
		end
	end

	// plain scan register, written only while vector access is closed
	always @(posedge core_clk) begin
		if (srst) begin
			cal_coeff_scan <= `CCR_RST_COEFF_SCAN;
		end else if (reg_wr_en & sel(reg_addr, `CCR_OFF_COEFF_SCAN) & ~cal_config_0[`CCR_VEC_EN_BIT]) begin
			cal_coeff_scan <= reg_wr_data;
		end
	end

	// calibration control; the trigger is a one-cycle pulse and never stores
	always @(posedge core_clk) begin
		if (srst) begin
			cal_config_0 <= `CCR_RST_CAL_CONFIG_0; // RULE_11
			foreground_cal_trigger <= 1'b0;
		end else begin
			foreground_cal_trigger <= 1'b0;
			if (cfg0_wr) begin
				// trigger bit reads back zero
				cal_config_0 <= reg_wr_data & ~(8'h01 << `CCR_CAL_TRIG_BIT); // RULE_12
				foreground_cal_trigger <= reg_wr_data[`CCR_CAL_TRIG_BIT]; // RULE_12
			end
		end
	end

	// scan pointer; each scan access while vector access is open moves to the next word, wrapping at the end
	// rewind and step never meet, since they come from different offsets
	always @(posedge core_clk) begin
		if (srst) begin
			vec_ptr <= {`CCR_VEC_AW{1'b0}};
		end else if (scan_open) begin
			vec_ptr <= {`CCR_VEC_AW{1'b0}}; // RULE_13
		end else if ((reg_wr_en | reg_rd_en) & scan_hit) begin
			vec_ptr <= vec_ptr + {{(`CCR_VEC_AW-1){1'b0}}, 1'b1}; // RULE_13
		end
	end

	// read mux; unmapped and reserved offsets return zero
	always @(posedge core_clk) begin
		if (srst) begin
			reg_rd_data <= 8'h00;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				case (reg_addr)
					`CCR_OFF_SYSREF_DELAY: reg_rd_data <= sysref_delay_ctrl; // RULE_02
					`CCR_OFF_ANALOG_MISC: reg_rd_data <= analog_misc_ctrl; // RULE_03
					`CCR_OFF_INPUT_CLAMP: reg_rd_data <= input_clamp_ctrl; // RULE_06
					`CCR_OFF_LANE_DRIVER: reg_rd_data <= lane_driver_cfg; // RULE_08
					`CCR_OFF_CAL_CONFIG_0: reg_rd_data <= cal_config_0; // RULE_11
					`CCR_OFF_CAL_CONFIG_1: reg_rd_data <= cal_config_1; // RULE_14
					`CCR_OFF_BG_CAL: reg_rd_data <= background_cal_ctrl;
					`CCR_OFF_PAT_OVR: reg_rd_data <= test_pattern_overrange_en;
					// vector data is the store's registered output, read at the pointer held one cycle earlier
					`CCR_OFF_COEFF_SCAN: reg_rd_data <= cal_config_0[`CCR_VEC_EN_BIT] ? vec_q : cal_coeff_scan; // RULE_13
					`CCR_OFF_CAL_STATE: reg_rd_data <= cal_status_in;
					`CCR_OFF_TIMING_CAL: reg_rd_data <= timing_cal_ctrl;
					default: reg_rd_data <= 8'h00; // RULE_10
				endcase
			end
		end
	end
endmodule // ccr_regs
`default_nettype wire

// [ccr_defines.vh]
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH
// register offsets
`define CCR_ADDR_W 12
`define CCR_OFF_SYSREF_DELAY 12'h032
`define CCR_OFF_ANALOG_MISC 12'h033
`define CCR_OFF_INPUT_CLAMP 12'h034
`define CCR_OFF_LANE_DRIVER 12'h040
`define CCR_OFF_CAL_CONFIG_0 12'h050
`define CCR_OFF_CAL_CONFIG_1 12'h051
`define CCR_OFF_BG_CAL 12'h057
`define CCR_OFF_PAT_OVR 12'h058
`define CCR_OFF_COEFF_SCAN 12'h05a
`define CCR_OFF_CAL_STATE 12'h05b
`define CCR_OFF_TIMING_CAL 12'h066
// reset values
`define CCR_RST_SYSREF_DELAY 8'h80
`define CCR_RST_ANALOG_MISC 8'hc3
`define CCR_RST_INPUT_CLAMP 8'h2f
`define CCR_RST_LANE_DRIVER 8'h04
`define CCR_RST_CAL_CONFIG_0 8'h06
`define CCR_RST_CAL_CONFIG_1 8'hf4
`define CCR_RST_BG_CAL 8'h10
`define CCR_RST_PAT_OVR 8'h00
`define CCR_RST_COEFF_SCAN 8'h00
`define CCR_RST_TIMING_CAL 8'h02
// field positions
`define CCR_DELAY_MSB 3
`define CCR_DELAY_LSB 0
`define CCR_SYNC_PD_BIT 2
`define CCR_CLAMP_EN_BIT 5
`define CCR_PREEMPH_MSB 3
`define CCR_PREEMPH_LSB 0
`define CCR_VEC_EN_BIT 4
`define CCR_CAL_TRIG_BIT 3
// calibration vector store
`define CCR_VEC_W 8
`define CCR_VEC_AW 4
`define CCR_VEC_DEPTH 16
`endif

// [ccr_vec_mem.v]
`include "ccr_defines.vh"
`default_nettype none
module ccr_vec_mem (
	input wire core_clk,
	input wire we,
	input wire [`CCR_VEC_AW-1:0] addr,
	input wire [`CCR_VEC_W-1:0] wdata,
	output reg [`CCR_VEC_W-1:0] rdata
);
	reg [`CCR_VEC_W-1:0] mem [0:`CCR_VEC_DEPTH-1];

	// registered read, write-first so a read after a write sees new data
	always @(posedge core_clk) begin
		if (we) begin
			mem[addr] <= wdata;
			rdata <= wdata;
		end else begin
			rdata <= mem[addr];
		end
	end
endmodule // ccr_vec_mem
`default_nettype wire

// [ccr_regs_sva.sv]
`default_nettype none
module ccr_regs_sva (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_en,
	input wire logic reg_rd_valid,
	input wire logic [3:0] sysref_delay_step,
	input wire logic sync_diff_powerdown,
	input wire logic input_clamp_en,
	input wire logic [3:0] lane_preemphasis,
	input wire logic foreground_cal_trigger
);
	timeunit 1ns;
	timeprecision 1ps;
	// one domain, so clock and reset are given once
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_rdv; reg_rd_en |=> reg_rd_valid; endproperty
	a_rdv: assert property (p_rdv) else $error("read valid missing");
	property p_rdq; !reg_rd_en |=> !reg_rd_valid; endproperty
	a_rdq: assert property (p_rdq) else $error("read valid without read");
	property p_dly; reg_wr_en && reg_addr == 12'h032 |=> sysref_delay_step == $past(reg_wr_data[3:0]); endproperty
	a_dly: assert property (p_dly) else $error("delay step wrong");
	property p_pd; reg_wr_en && reg_addr == 12'h033 |=> sync_diff_powerdown == $past(reg_wr_data[2]); endproperty
	a_pd: assert property (p_pd) else $error("sync powerdown wrong");
	property p_cl; reg_wr_en && reg_addr == 12'h034 |=> input_clamp_en == $past(reg_wr_data[5]); endproperty
	a_cl: assert property (p_cl) else $error("clamp enable wrong");
	property p_pre; reg_wr_en && reg_addr == 12'h040 |=> lane_preemphasis == $past(reg_wr_data[3:0]); endproperty
	a_pre: assert property (p_pre) else $error("preemphasis wrong");
	property p_trg; reg_wr_en && reg_addr == 12'h050 && reg_wr_data[3] |=> foreground_cal_trigger; endproperty
	a_trg: assert property (p_trg) else $error("trigger pulse missing");
	property p_trq; !(reg_wr_en && reg_addr == 12'h050 && reg_wr_data[3]) |=> !foreground_cal_trigger; endproperty
	a_trq: assert property (p_trq) else $error("trigger without cause");
	c_trg: cover property (foreground_cal_trigger);
	c_rd: cover property (reg_rd_valid);
	c_cl: cover property (reg_wr_en && reg_addr == 12'h034 ##1 !input_clamp_en);
endmodule // ccr_regs_sva
bind ccr_regs ccr_regs_sva u_sva (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
	.reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_valid(reg_rd_valid),
	.sysref_delay_step(sysref_delay_step), .sync_diff_powerdown(sync_diff_powerdown),
	.input_clamp_en(input_clamp_en), .lane_preemphasis(lane_preemphasis),
	.foreground_cal_trigger(foreground_cal_trigger));
`default_nettype wire

// [ccr_regs_tb.sv]
`default_nettype none
module ccr_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic [7:0] reg_wr_data = 8'h00;
	logic [7:0] reg_rd_data;
	logic reg_rd_valid, sync_diff_powerdown, input_clamp_en, foreground_cal_trigger;
	logic [3:0] sysref_delay_step, lane_preemphasis;
	logic vector_access_en;
	logic [7:0] cal_config_1_out, background_cal_out, test_pattern_overrange_out, timing_cal_out;
	int n_mismatch = 0;
	int checks_done = 0;
	// offset, reset value, write data, read-back
	logic [35:0] rows [13] = '{36'h032805f5f, 36'h033c30404, 36'h0342f0f0f, 36'h04004ff0f,
		36'h05006e0e0, 36'h051f43c3c, 36'h05710a5a5, 36'h058000707, 36'h05a009999,
		36'h05b3a113a, 36'h045007700, 36'h06c005500, 36'h06602c8c8};
	ccr_regs dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .cal_status_in(8'h3a),
		.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .sysref_delay_step(sysref_delay_step),
		.sync_diff_powerdown(sync_diff_powerdown), .input_clamp_en(input_clamp_en),
		.lane_preemphasis(lane_preemphasis), .vector_access_en(vector_access_en),
		.foreground_cal_trigger(foreground_cal_trigger), .cal_config_1_out(cal_config_1_out),
		.background_cal_out(background_cal_out), .test_pattern_overrange_out(test_pattern_overrange_out),
		.timing_cal_out(timing_cal_out));
	initial forever #10 core_clk = ~core_clk;
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// strobes rise after one edge and drop after the next, leaving an idle cycle between calls
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_en <= 1'b1;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
		@(negedge core_clk);
		chk({7'h0, reg_rd_valid}, 8'h01);
		chk(reg_rd_data, e);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// cut a hang short well past the expected run length
	initial begin
		repeat (3000) @(posedge core_clk);
		n_mismatch++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			rd(rows[i][35:24], rows[i][23:16]);
			wr(rows[i][35:24], rows[i][15:8]);
			rd(rows[i][35:24], rows[i][7:0]);
		end
		@(negedge core_clk);
		chk({4'h0, sysref_delay_step}, 8'h0f);
		chk({7'h0, sync_diff_powerdown}, 8'h01);
		chk({7'h0, input_clamp_en}, 8'h00);
		chk({4'h0, lane_preemphasis}, 8'h0f);
		chk(cal_config_1_out, 8'h3c);
		chk(background_cal_out, 8'ha5);
		chk(test_pattern_overrange_out, 8'h07);
		chk(timing_cal_out, 8'hc8);
		// differential sync in use: the receiver is powered again
		wr(12'h033, 8'hc3);
		@(negedge core_clk);
		chk({7'h0, sync_diff_powerdown}, 8'h00);
		wr(12'h050, 8'h08);
		@(negedge core_clk);
		chk({7'h0, foreground_cal_trigger}, 8'h01);
		rd(12'h050, 8'h00);
		wr(12'h034, 8'h20);
		@(negedge core_clk);
		chk({7'h0, input_clamp_en}, 8'h01);
		// scan pointer restarts when vector access is re-enabled
		wr(12'h050, 8'h16);
		@(negedge core_clk);
		chk({7'h0, vector_access_en}, 8'h01);
		wr(12'h05a, 8'haa);
		wr(12'h05a, 8'hbb);
		wr(12'h050, 8'h06);
		@(negedge core_clk);
		chk({7'h0, vector_access_en}, 8'h00);
		wr(12'h050, 8'h16);
		rd(12'h05a, 8'haa);
		rd(12'h05a, 8'hbb);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		// outputs are back at their defaults before the first access
		@(negedge core_clk);
		chk(reg_rd_data, 8'h00);
		chk({4'h0, sysref_delay_step}, 8'h00);
		chk({4'h0, lane_preemphasis}, 8'h04);
		chk({7'h0, sync_diff_powerdown}, 8'h00);
		chk({7'h0, input_clamp_en}, 8'h01);
		chk({7'h0, vector_access_en}, 8'h00);
		chk({7'h0, foreground_cal_trigger}, 8'h00);
		rd(12'h032, 8'h80);
		rd(12'h034, 8'h2f);
		conclude();
	end
endmodule // ccr_regs_tb
`default_nettype wire
